// file: rtl/fast_osc_stable_pkg.sv
// Constants and types for the internal oscillator frequency switch
package fast_osc_stable_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] OSC_CONTROL_IDX = 12'h008F;
    localparam logic [11:0] IRQ_STATUS_IDX  = 12'h00A0;
    localparam logic [11:0] IRQ_MASK_IDX    = 12'h00A1;
    // Control register fields
    localparam int FSEL_LSB   = 4;
    localparam int FSEL_MSB   = 6;
    localparam int STABLE_BIT = 2;
    localparam logic [2:0] FSEL_RESET   = 3'h0;
    localparam logic [2:0] FSEL_FAST    = 3'h7;
    localparam logic [2:0] FSEL_SLOW    = 3'h0;
    localparam logic       STABLE_RESET = 1'b0;
    // Interrupt status fields
    localparam int EV_SWITCH_DONE = 0;
    localparam int EV_STABLE      = 1;
    localparam int EV_WIDTH       = 2;
    localparam logic [1:0] EV_RESET = 2'h0;
    // Handover and settling timing
    localparam int HANDOVER_EDGES = 8;
    localparam int SETTLE_TIME_US = 4000;
    localparam int CLOCK_MHZ      = 125;
    localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLOCK_MHZ;
    localparam int POSTSCALE_BITS = 6;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        SW_RUN       = 2'b00,
        SW_WAIT_FALL = 2'b01,
        SW_HOLD_LOW  = 2'b10
    } fast_osc_stable_state_e;
endpackage

// file: rtl/fast_osc_stable_switch.sv
// Glitch-free internal oscillator frequency switch with AXI4-Lite registers
// Notes on behaviour
// - Select code 111..000 picks 8M, 4M, 2M, 1M, 500k, 250k, 125k, 31.25k.
// - 111 routes fast source direct, 000 slow source direct, others postscaler.
// - Select field writable any time; every change starts a switch sequence.
// - Leaving 000 for nonzero clears stable flag and starts about 4 ms delay.
// - During settling the new unsettled source keeps clocking the system.
// - Nonzero to nonzero change: no delay, stable right after handover.
// - Stable flag stays set across switches between nonzero codes.
// - On a change wait for falling edge of current clock, then hold low.
// - While low, count eight falling edges of requested clock, then connect.
// - Nonzero to 000 completes right after the handover, no settling step.
// - Read-only stable flag at bit 2, one when stable, resets to zero.
// - Bits 7, 3, 1, 0 unimplemented: writes ignored, read as zero.
//
// Implementation choice: the AXI4-Lite register port.
module fast_osc_stable_switch
#(
    parameter int ADDR_W        = 12,
    parameter int SETTLE_CYCLES = fast_osc_stable_pkg::SETTLE_CYCLES
)
(
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    input  wire logic              FAST_SRC,
    input  wire logic              SLOW_SRC,
    output logic                   CLOCK_OUT,
    output logic                   FAST_OSC_STABLE,
    output logic [2:0]             ACTIVE_SELECT,
    output logic                   IRQ,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY
);
    localparam int SC_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SC_W-1:0] SETTLE_LOAD = SC_W'(SETTLE_CYCLES - 1);
    localparam logic [3:0] EDGE_LAST = 4'(fast_osc_stable_pkg::HANDOVER_EDGES - 1);

    // Source vector: fast source, postscaler taps, slow source
    function automatic logic src_level(input logic [7:0] v,
                                       input logic [2:0] c);
        logic r;
        r = 1'b0;
        if (c == fast_osc_stable_pkg::FSEL_FAST)
            r = v[7];
        else if (c == fast_osc_stable_pkg::FSEL_SLOW)
            r = v[0];
        else
            r = v[3'(7 - c)];
        return r;
    endfunction

    fast_osc_stable_pkg::fast_osc_stable_state_e state;
    logic [2:0]  req_sel;
    logic [2:0]  cur_sel;
    logic [3:0]  edge_cnt;
    logic        fast_prev;
    logic [fast_osc_stable_pkg::POSTSCALE_BITS-1:0] post_cnt;
    logic [7:0]  src_vec;
    logic [7:0]  src_prev;
    logic        stable;
    logic        settling;
    logic [SC_W-1:0] settle_cnt;
    logic [1:0]  ev_status;
    logic [1:0]  ev_mask;
    logic        sel_change;
    logic [2:0]  wr_sel;
    logic        cur_fall;
    logic        req_fall;
    logic        switch_done;
    logic        stable_rise;
    logic [ADDR_W-1:0] aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_fire;
    logic        rd_fire;
    logic [ADDR_W-1:0] aw_idx;
    logic [ADDR_W-1:0] ar_idx;

    assign src_vec  = {FAST_SRC, post_cnt, SLOW_SRC};
    // Falling edges seen on the sampled sources
    assign cur_fall = src_level(src_prev, cur_sel)
                      & ~src_level(src_vec, cur_sel);
    assign req_fall = src_level(src_prev, req_sel)
                      & ~src_level(src_vec, req_sel);
    assign switch_done = (state == fast_osc_stable_pkg::SW_HOLD_LOW) && req_fall
                         && (edge_cnt == EDGE_LAST) && !sel_change;
    assign aw_idx  = aw_addr >> 2;
    assign ar_idx  = ARADDR >> 2;
    assign wr_fire = aw_held && w_held && !BVALID;
    assign rd_fire = ARVALID && ARREADY;
    assign wr_sel  = w_data[fast_osc_stable_pkg::FSEL_MSB:fast_osc_stable_pkg::FSEL_LSB];
    assign sel_change = wr_fire && w_strb[0]
                        && (aw_idx == fast_osc_stable_pkg::OSC_CONTROL_IDX)
                        && (wr_sel != req_sel);
    assign stable_rise = settling && (settle_cnt == '0) && !sel_change;

    // Postscaler divides the fast source by powers of two
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            fast_prev <= 1'b0;
            post_cnt  <= '0;
            src_prev  <= 8'h00;
        end
        else
        begin
            fast_prev <= FAST_SRC;
            if (FAST_SRC && !fast_prev)
                post_cnt <= post_cnt + 1'b1;
            src_prev <= src_vec;
        end
    end

    // Requested select: software view of the field
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            req_sel <= fast_osc_stable_pkg::FSEL_RESET;
        else if (sel_change)
            req_sel <= wr_sel;
    end

    // Handover sequencer; output is low for the whole hold phase
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state     <= fast_osc_stable_pkg::SW_RUN;
            cur_sel   <= fast_osc_stable_pkg::FSEL_RESET;
            edge_cnt  <= 4'h0;
            CLOCK_OUT <= 1'b0;
        end
        else
        begin
            case (state)
                fast_osc_stable_pkg::SW_RUN:
                begin
                    CLOCK_OUT <= src_level(src_vec, cur_sel);
                    if (sel_change)
                        state <= fast_osc_stable_pkg::SW_WAIT_FALL;
                end
                fast_osc_stable_pkg::SW_WAIT_FALL:
                begin
                    if (cur_fall)
                    begin
                        CLOCK_OUT <= 1'b0;
                        edge_cnt  <= 4'h0;
                        state     <= fast_osc_stable_pkg::SW_HOLD_LOW;
                    end
                    else
                        CLOCK_OUT <= src_level(src_vec, cur_sel);
                end
                fast_osc_stable_pkg::SW_HOLD_LOW:
                begin
                    CLOCK_OUT <= 1'b0;
                    if (sel_change)
                        edge_cnt <= 4'h0;
                    else if (switch_done)
                    begin
                        cur_sel <= req_sel;
                        state   <= fast_osc_stable_pkg::SW_RUN;
                    end
                    else if (req_fall)
                        edge_cnt <= edge_cnt + 4'h1;
                end
                default:
                begin
                    state     <= fast_osc_stable_pkg::SW_RUN;
                    CLOCK_OUT <= 1'b0;
                end
            endcase
        end
    end

    // Stable flag and settling delay
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            stable     <= fast_osc_stable_pkg::STABLE_RESET;
            settling   <= 1'b0;
            settle_cnt <= '0;
        end
        else if (sel_change)
            settling <= 1'b0;
        else if (switch_done)
        begin
            if (req_sel == fast_osc_stable_pkg::FSEL_SLOW)
                settling <= 1'b0;
            else if (cur_sel == fast_osc_stable_pkg::FSEL_SLOW || settling)
            begin
                // Leaving the slow source: clear stable and start the delay
                stable     <= 1'b0;
                settling   <= 1'b1;
                settle_cnt <= SETTLE_LOAD;
            end
            else
                stable <= 1'b1;
        end
        else if (settling)
        begin
            if (settle_cnt == '0)
            begin
                settling <= 1'b0;
                stable   <= 1'b1;
            end
            else
                settle_cnt <= settle_cnt - 1'b1;
        end
    end

    // Sticky events; set wins over the read that clears them
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            ev_status <= fast_osc_stable_pkg::EV_RESET;
        else
        begin
            logic [1:0] next_status;
            next_status = ev_status;
            if (rd_fire && ar_idx == fast_osc_stable_pkg::IRQ_STATUS_IDX)
                next_status = 2'h0;
            if (switch_done)
                next_status[fast_osc_stable_pkg::EV_SWITCH_DONE] = 1'b1;
            if (stable_rise)
                next_status[fast_osc_stable_pkg::EV_STABLE] = 1'b1;
            ev_status <= next_status;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            ev_mask <= fast_osc_stable_pkg::EV_RESET;
        else if (wr_fire && w_strb[0] && aw_idx == fast_osc_stable_pkg::IRQ_MASK_IDX)
            ev_mask <= w_data[fast_osc_stable_pkg::EV_WIDTH-1:0];
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            IRQ             <= 1'b0;
            FAST_OSC_STABLE <= 1'b0;
            ACTIVE_SELECT   <= fast_osc_stable_pkg::FSEL_RESET;
        end
        else
        begin
            IRQ             <= |(ev_status & ev_mask);
            FAST_OSC_STABLE <= stable;
            ACTIVE_SELECT   <= cur_sel;
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            BVALID  <= 1'b0;
            BRESP   <= fast_osc_stable_pkg::RESP_OKAY;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_addr <= AWADDR;
                aw_held <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_data <= WDATA;
                w_strb <= WSTRB;
                w_held <= 1'b1;
                WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                BVALID  <= 1'b1;
                if (aw_idx == fast_osc_stable_pkg::OSC_CONTROL_IDX
                    || aw_idx == fast_osc_stable_pkg::IRQ_STATUS_IDX
                    || aw_idx == fast_osc_stable_pkg::IRQ_MASK_IDX)
                    BRESP <= fast_osc_stable_pkg::RESP_OKAY;
                else
                    BRESP <= fast_osc_stable_pkg::RESP_SLVERR;
            end
            if (BVALID && BREADY)
            begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // Read channel; status read clears the sticky bits
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= fast_osc_stable_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= fast_osc_stable_pkg::RESP_OKAY;
            RDATA   <= 32'h0000_0000;
            if (ar_idx == fast_osc_stable_pkg::OSC_CONTROL_IDX)
            begin
                RDATA[fast_osc_stable_pkg::FSEL_MSB:fast_osc_stable_pkg::FSEL_LSB] <= req_sel;
                RDATA[fast_osc_stable_pkg::STABLE_BIT] <= stable;
            end
            else if (ar_idx == fast_osc_stable_pkg::IRQ_STATUS_IDX)
                RDATA[fast_osc_stable_pkg::EV_WIDTH-1:0] <= ev_status;
            else if (ar_idx == fast_osc_stable_pkg::IRQ_MASK_IDX)
                RDATA[fast_osc_stable_pkg::EV_WIDTH-1:0] <= ev_mask;
            else
                RRESP <= fast_osc_stable_pkg::RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end
endmodule

// file: dv/fast_osc_stable_switch_props.sv
// Concurrent checks on the ports of the oscillator frequency switch
module fast_osc_stable_props
#(
    parameter int SETTLE_CYCLES = 50
)
(
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    input wire logic        FAST_SRC,
    input wire logic        SLOW_SRC,
    input wire logic        CLOCK_OUT,
    input wire logic        FAST_OSC_STABLE,
    input wire logic [2:0]  ACTIVE_SELECT,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    logic [2:0] prev_sel;
    int         low_cnt;
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            prev_sel <= 3'h0;
        else
            prev_sel <= ACTIVE_SELECT;
    end
    // Cycles spent unstable on one connected code
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            low_cnt <= 0;
        else if (FAST_OSC_STABLE || ACTIVE_SELECT != prev_sel)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    sequence aw_w_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence ar_taken;
        ARVALID && ARREADY;
    endsequence
    chk_switch_low_hold: assert property (
        $changed(ACTIVE_SELECT) |-> !$past(CLOCK_OUT) && !$past(CLOCK_OUT, 2))
        else $error("select changed while clock output was not held low");
    chk_fast_direct: assert property (
        (ACTIVE_SELECT == fast_osc_stable_pkg::FSEL_FAST && CLOCK_OUT) |->
        ($past(FAST_SRC) || $past(FAST_SRC, 2) || $past(FAST_SRC, 3)))
        else $error("fast code high without fast source high");
    chk_slow_direct: assert property (
        (ACTIVE_SELECT == fast_osc_stable_pkg::FSEL_SLOW && CLOCK_OUT) |->
        ($past(SLOW_SRC) || $past(SLOW_SRC, 2) || $past(SLOW_SRC, 3)))
        else $error("slow code high without slow source high");
    chk_stable_fall_src: assert property (
        $fell(FAST_OSC_STABLE) |-> ($past(ACTIVE_SELECT) == 3'h0 ||
        $past(ACTIVE_SELECT, 2) == 3'h0))
        else $error("stable flag fell without leaving the slow code");
    chk_settle_count: assert property (
        $rose(FAST_OSC_STABLE) |-> low_cnt >= SETTLE_CYCLES - 2 &&
        low_cnt <= SETTLE_CYCLES + 3 && ACTIVE_SELECT != 3'h0)
        else $error("stable flag rose off the settling count");
    chk_write_answer: assert property (
        aw_w_taken |-> ##[1:3] BVALID)
        else $error("write taken without a response");
    chk_read_answer: assert property (
        ar_taken |=> RVALID)
        else $error("read taken without data");
    chk_read_hold: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before handshake");
    chk_unimpl_zero: assert property (
        RVALID |-> RDATA[31:7] == 25'h0 && !RDATA[3])
        else $error("unimplemented bits read nonzero");
endmodule

bind fast_osc_stable_switch fast_osc_stable_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props
(
    .CLOCK(CLOCK), .RESET_N(RESET_N), .FAST_SRC(FAST_SRC),
    .SLOW_SRC(SLOW_SRC), .CLOCK_OUT(CLOCK_OUT),
    .FAST_OSC_STABLE(FAST_OSC_STABLE), .ACTIVE_SELECT(ACTIVE_SELECT),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA)
);

// file: dv/fast_osc_stable_switch_tb.sv
// Self-checking bench for the oscillator frequency switch
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module fast_osc_stable_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ST = 50;
    localparam logic [11:0] A_CTL = fast_osc_stable_pkg::OSC_CONTROL_IDX << 2;
    localparam logic [11:0] A_STS = fast_osc_stable_pkg::IRQ_STATUS_IDX << 2;
    localparam logic [11:0] A_MSK = fast_osc_stable_pkg::IRQ_MASK_IDX << 2;
    logic        CLOCK, RESET_N, FAST_SRC, SLOW_SRC, CLOCK_OUT, IRQ;
    logic        FAST_OSC_STABLE, AWVALID, AWREADY, WVALID, WREADY;
    logic        BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [2:0]  ACTIVE_SELECT;
    logic [1:0]  BRESP, RRESP, r;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0]  WSTRB;
    logic [6:0]  fcnt;
    int          miscompares, checks, n, p;
    fast_osc_stable_switch #(.SETTLE_CYCLES(ST)) i_dut
    (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .FAST_SRC(FAST_SRC),
        .SLOW_SRC(SLOW_SRC), .CLOCK_OUT(CLOCK_OUT),
        .FAST_OSC_STABLE(FAST_OSC_STABLE), .ACTIVE_SELECT(ACTIVE_SELECT),
        .IRQ(IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
    );
    always #4 CLOCK = ~CLOCK;
    // Sources scaled down: fast period 16 cycles, slow period 128 cycles
    always @(posedge CLOCK)
    begin
        fcnt <= fcnt + 7'h01;
        FAST_SRC <= fcnt[3];
        SLOW_SRC <= fcnt[6];
    end
    function automatic logic [31:0] ctl(input logic [2:0] s, input logic f);
        return {25'h0, s, 1'h0, f, 2'h0};
    endfunction
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge CLOCK);
            if (AWREADY === 1'h1)
                AWVALID <= 1'h0;
            if (WREADY === 1'h1)
                WVALID <= 1'h0;
            if (BVALID === 1'h1)
                break;
        end
        // A write that never answers counts against the run
        if (n == 50)
            miscompares++;
        r = BRESP;
        BREADY <= 1'h0;
    endtask
    // Ready is raised late so the slave must hold its answer
    task automatic axi_rd(input logic [11:0] a);
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge CLOCK);
            if (ARREADY === 1'h1)
                ARVALID <= 1'h0;
            if (RVALID === 1'h1 && RREADY === 1'h1)
                break;
            if (RVALID === 1'h1)
                RREADY <= 1'h1;
        end
        if (n == 50)
            miscompares++;
        d = RDATA;
        r = RRESP;
        RREADY <= 1'h0;
    endtask
    task automatic wait_sel(input logic [2:0] c);
        n = 0;
        while (ACTIVE_SELECT !== c && n < 20000)
        begin
            @(posedge CLOCK);
            n++;
        end
        if (n >= 20000)
            miscompares++;
    endtask
    task automatic wait_stable();
        for (n = 0; n < ST + 100 && FAST_OSC_STABLE !== 1'h1; n++)
            @(posedge CLOCK);
    endtask
    task automatic meas();
        realtime t0;
        @(posedge CLOCK_OUT);
        t0 = $realtime;
        @(posedge CLOCK_OUT);
        p = int'(($realtime - t0) / 8.0);
    endtask
    task automatic t_reset();
        axi_rd(A_CTL);
        `CHK(d, 32'h0000_0000)
        axi_rd(A_MSK);
        `CHK(d, 32'h0000_0000)
    endtask
    task automatic t_leave_slow();
        axi_wr(A_CTL, 32'hFFFF_FFFF);
        `CHK(r, fast_osc_stable_pkg::RESP_OKAY)
        axi_rd(A_CTL);
        `CHK(d, ctl(3'h7, 1'h0))
        wait_sel(3'h7);
        `CHK(FAST_OSC_STABLE, 1'h0)
        meas();
        `CHK(p, 16)
        `CHK(FAST_OSC_STABLE, 1'h0)
        `CHK(IRQ, 1'h0)
        axi_wr(A_MSK, 32'h0000_0002);
        wait_stable();
        `CHK(FAST_OSC_STABLE, 1'h1)
        repeat (2) @(posedge CLOCK);
        `CHK(IRQ, 1'h1)
        axi_rd(A_STS);
        `CHK(d, 32'h0000_0003)
        repeat (2) @(posedge CLOCK);
        `CHK(IRQ, 1'h0)
        axi_rd(A_CTL);
        `CHK(d, ctl(3'h7, 1'h1))
    endtask
    task automatic t_walk();
        for (int c = 6; c >= 1; c--)
        begin
            axi_wr(A_CTL, 32'(c) << 4);
            wait_sel(3'(c));
            `CHK((n >= 7 * (16 << (7 - c))), 1'h1)
            `CHK(FAST_OSC_STABLE, 1'h1)
            meas();
            `CHK(p, 16 << (7 - c))
        end
    endtask
    task automatic t_to_slow();
        axi_wr(A_CTL, 32'h0000_0000);
        wait_sel(3'h0);
        `CHK((n >= 7 * 128), 1'h1)
        meas();
        `CHK(p, 128)
        `CHK(FAST_OSC_STABLE, 1'h1)
    endtask
    task automatic t_restart();
        axi_wr(A_CTL, 32'h0000_0070);
        axi_wr(A_CTL, 32'h0000_0030);
        wait_sel(3'h3);
        `CHK(FAST_OSC_STABLE, 1'h0)
        wait_stable();
        `CHK(FAST_OSC_STABLE, 1'h1)
        meas();
        `CHK(p, 256)
    endtask
    task automatic t_unmapped();
        axi_wr(12'h300, 32'hFFFF_FFFF);
        `CHK(r, fast_osc_stable_pkg::RESP_SLVERR)
        axi_rd(12'h300);
        `CHK(d, 32'h0000_0000)
        `CHK(r, fast_osc_stable_pkg::RESP_SLVERR)
        axi_rd(A_MSK);
        `CHK(d, 32'h0000_0002)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge CLOCK);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        {CLOCK, RESET_N, FAST_SRC, SLOW_SRC, fcnt} = '0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hF;
        miscompares = 0;
        checks = 0;
        repeat (4) @(posedge CLOCK);
        RESET_N <= 1'h1;
        t_reset();
        t_leave_slow();
        t_walk();
        t_to_slow();
        t_restart();
        t_unmapped();
        tally_and_finish();
    end
endmodule
